// ===== hdl/dpram_host_pkg.sv
// Purpose: constants and carriers for the host controller of one dual-port ram port
// Assumes: 250 MHz ref_clk_i, device pins asynchronous to it
// Notes: device times are rounded up to whole clock cycles
package dpram_host_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 9;
  localparam logic [11:0] MBOX_LEFT_ADDR  = 12'h0ffe;
  localparam logic [11:0] MBOX_RIGHT_ADDR = 12'h0fff;
  // software register offsets
  localparam logic [3:0] REG_CMD    = 4'h0;
  localparam logic [3:0] REG_ADDR   = 4'h1;
  localparam logic [3:0] REG_WDATA  = 4'h2;
  localparam logic [3:0] REG_RDATA  = 4'h3;
  localparam logic [3:0] REG_STATUS = 4'h4;
  // command field codes in REG_CMD bits 1:0
  localparam logic [1:0] CMD_RD     = 2'h0;
  localparam logic [1:0] CMD_WR     = 2'h1;
  localparam logic [1:0] CMD_TOK_RD = 2'h2;
  localparam logic [1:0] CMD_TOK_WR = 2'h3;
  localparam int CLK_PS = 4000;
  // device times in ps
  localparam int T_SETUP_PS    = 12000;
  localparam int T_PULSE_PS    = 20000;
  localparam int T_ACCESS_PS   = 25000;
  localparam int T_HOLD_PS     = 2000;
  localparam int T_TOKGAP_PS   = 10000; // token_update_gap
  localparam int T_TOKW2R_PS   = 5000;  // token_write_to_read
  localparam int T_FLOW_PS     = 30000; // port_flowthrough_delay
  localparam logic [3:0] SETUP_CYC  = 4'((T_SETUP_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [3:0] PULSE_CYC  = 4'((T_PULSE_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [3:0] ACCESS_CYC = 4'((T_ACCESS_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [3:0] HOLD_CYC   = 4'((T_HOLD_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [3:0] GAP_CYC    = 4'((T_TOKGAP_PS + T_TOKW2R_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [3:0] FLOW_CYC   = 4'((T_FLOW_PS + CLK_PS - 1) / CLK_PS);
  localparam logic [3:0] SYNC_RST   = 4'h0;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SETUP = 3'b001,
    ST_PULSE = 3'b010,
    ST_HOLD  = 3'b011,
    ST_READ  = 3'b100,
    ST_GAP   = 3'b101
  } host_state_e;

  typedef struct packed {
    logic              sel_b;
    logic              tok_sel_b;
    logic              wstrobe_b;
    logic              oe_b;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] dout;
    logic              dout_en;
  } port_pins_s;

  typedef struct packed {
    logic [2:0] mbox;
    logic [2:0] busy;
  } sync_s;
endpackage : dpram_host_pkg

// ===== hdl/pin_sync.sv
// Purpose: three-stage synchroniser with agreement filter for device flag pins
// Assumes: inputs asynchronous to ref_clk_i
// Notes: second stage is read only by the third and by the filter compare
`timescale 1ns/10ps
`default_nettype none
module pin_sync (
  input  wire logic ref_clk_i,
  input  wire logic rst_b_i,
  input  wire logic pin_i,
  output logic      level_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } st_s;
  st_s st_reg;
  st_s st_next;
  always_comb begin
    st_next     = st_reg;
    st_next.s1  = pin_i;
    st_next.s2  = st_reg.s1;
    st_next.s3  = st_reg.s2;
    if (st_reg.s2 == st_reg.s3) begin
      st_next.lvl = st_reg.s3;
    end
  end
  // flags idle high on the pins; reset value is a constant
  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg <= 4'hf;
    end else begin
      st_reg <= st_next;
    end
  end
  assign level_o = st_reg.lvl;
endmodule : pin_sync
`default_nettype wire

// ===== hdl/dpram_host.sv
// Purpose: host controller driving one port of an asynchronous dual-port ram
// Assumes: one 250 MHz clock; device timing met by fixed cycle counts
// Notes: software issues one access at a time through a plain register port
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module dpram_host (
  input  wire logic                              ref_clk_i,
  input  wire logic                              rst_b_i,
  input  wire logic [3:0]                        sw_addr_i,
  input  wire logic [31:0]                       sw_wdata_i,
  input  wire logic                              sw_wr_i,
  input  wire logic                              sw_rd_i,
  output logic [31:0]                            sw_rdata_o,
  output logic                                   dev_ce_b_o,
  output logic                                   dev_tok_sel_b_o,
  output logic                                   dev_wstrobe_b_o,
  output logic                                   dev_oe_b_o,
  output logic [dpram_host_pkg::ADDR_W-1:0]      dev_addr_o,
  input  wire logic [dpram_host_pkg::DATA_W-1:0] dev_data_i,
  output logic [dpram_host_pkg::DATA_W-1:0]      dev_data_o,
  output logic                                   dev_data_oe_o,
  input  wire logic                              dev_mbox_b_i,
  input  wire logic                              dev_busy_b_i,
  output logic                                   dev_role_master_o
);
  typedef struct packed {
    dpram_host_pkg::host_state_e       st;
    dpram_host_pkg::port_pins_s        pins;
    logic [3:0]                        cnt;
    logic [1:0]                        cmd;
    logic                              role_master;
    logic [dpram_host_pkg::ADDR_W-1:0] addr;
    logic [dpram_host_pkg::DATA_W-1:0] wdata;
    logic [dpram_host_pkg::DATA_W-1:0] rdata;
    logic                              busy_seen;
    logic                              done;
    logic [31:0]                       rd_out;
  } host_s;

  host_s st_reg;
  host_s st_next;
  logic  mbox_b;
  logic  busy_b;

  pin_sync u_mbox (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (dev_mbox_b_i),
    .level_o   (mbox_b)
  );
  pin_sync u_busy (
    .ref_clk_i (ref_clk_i),
    .rst_b_i   (rst_b_i),
    .pin_i     (dev_busy_b_i),
    .level_o   (busy_b)
  );

  function automatic logic is_write(input logic [1:0] c);
    is_write = (c == dpram_host_pkg::CMD_WR) || (c == dpram_host_pkg::CMD_TOK_WR);
  endfunction : is_write

  function automatic logic is_token(input logic [1:0] c);
    is_token = c[1];
  endfunction : is_token

  always_comb begin
    st_next      = st_reg;
    // read data stand for exactly the cycle after the read strobe
    st_next.rd_out = 32'h0000_0000;
    if (sw_rd_i) begin
      case (sw_addr_i)
        dpram_host_pkg::REG_CMD:    st_next.rd_out = {30'h0000_0000, st_reg.cmd};
        dpram_host_pkg::REG_ADDR:   st_next.rd_out = {20'h0_0000, st_reg.addr};
        dpram_host_pkg::REG_WDATA:  st_next.rd_out = {23'h00_0000, st_reg.wdata};
        dpram_host_pkg::REG_RDATA:  st_next.rd_out = {23'h00_0000, st_reg.rdata};
        dpram_host_pkg::REG_STATUS: st_next.rd_out = {27'h000_0000, st_reg.role_master,
                                      st_reg.busy_seen, ~mbox_b, ~busy_b,
                                      st_reg.st != dpram_host_pkg::ST_IDLE};
        default:                    st_next.rd_out = 32'h0000_0000;
      endcase
    end
    // register writes ignored while an access runs; every write, command included, is taken only when idle
    if (sw_wr_i && st_reg.st == dpram_host_pkg::ST_IDLE) begin
      case (sw_addr_i)
        dpram_host_pkg::REG_ADDR:   st_next.addr = sw_wdata_i[dpram_host_pkg::ADDR_W-1:0];
        dpram_host_pkg::REG_WDATA:  st_next.wdata = sw_wdata_i[dpram_host_pkg::DATA_W-1:0];
        dpram_host_pkg::REG_STATUS: st_next.role_master = sw_wdata_i[4];
        dpram_host_pkg::REG_CMD: begin
          st_next.cmd       = sw_wdata_i[1:0];
          st_next.busy_seen = 1'b0;
          st_next.st        = dpram_host_pkg::ST_SETUP;
          st_next.cnt       = dpram_host_pkg::SETUP_CYC;
          // address loads with strobe high in the same cycle that the select falls
          st_next.pins.addr = st_reg.addr;
          st_next.pins.wstrobe_b = 1'b1;
          // select array or token latches, never both
          st_next.pins.sel_b     = is_token(sw_wdata_i[1:0]);
          st_next.pins.tok_sel_b = ~is_token(sw_wdata_i[1:0]);
          st_next.pins.oe_b      = is_write(sw_wdata_i[1:0]);
          st_next.pins.dout      = is_token(sw_wdata_i[1:0]) ?
                                   {{(dpram_host_pkg::DATA_W-1){1'b0}}, st_reg.wdata[0]} :
                                   st_reg.wdata;
          st_next.pins.dout_en   = is_write(sw_wdata_i[1:0]);
        end
        default: ;
      endcase
    end
    if (!busy_b && st_reg.st != dpram_host_pkg::ST_IDLE) begin
      st_next.busy_seen = 1'b1;
    end
    case (st_reg.st)
      dpram_host_pkg::ST_IDLE: ;
      dpram_host_pkg::ST_SETUP: begin
        if (st_reg.cnt > 4'h1) begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end else if (is_write(st_reg.cmd)) begin
          // slave array writes wait for busy to settle high; token writes do not
          if (st_reg.role_master || busy_b || is_token(st_reg.cmd)) begin
            st_next.pins.wstrobe_b = 1'b0;
            st_next.st  = dpram_host_pkg::ST_PULSE;
            st_next.cnt = dpram_host_pkg::PULSE_CYC; // oe high, so plain pulse width
          end
        end else begin
          st_next.st  = dpram_host_pkg::ST_READ;
          // cross-port data may need the flowthrough delay
          st_next.cnt = dpram_host_pkg::FLOW_CYC;
        end
      end
      dpram_host_pkg::ST_PULSE: begin
        if (st_reg.cnt > 4'h1) begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end else begin
          st_next.pins.wstrobe_b = 1'b1; // rising strobe takes the data
          st_next.st  = dpram_host_pkg::ST_HOLD;
          st_next.cnt = dpram_host_pkg::HOLD_CYC;
        end
      end
      dpram_host_pkg::ST_READ: begin
        if (st_reg.cnt > 4'h1) begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end else begin
          st_next.rdata = dev_data_i;
          st_next.pins.oe_b = 1'b1;
          st_next.st  = dpram_host_pkg::ST_HOLD;
          st_next.cnt = dpram_host_pkg::HOLD_CYC;
        end
      end
      dpram_host_pkg::ST_HOLD: begin
        if (st_reg.cnt > 4'h1) begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end else begin
          st_next.pins.sel_b     = 1'b1; // deselect lets the port power down
          st_next.pins.tok_sel_b = 1'b1;
          st_next.pins.dout_en   = 1'b0;
          st_next.st  = dpram_host_pkg::ST_GAP;
          st_next.cnt = dpram_host_pkg::GAP_CYC;
        end
      end
      dpram_host_pkg::ST_GAP: begin
        if (st_reg.cnt > 4'h1) begin
          st_next.cnt = st_reg.cnt - 4'h1;
        end else begin
          st_next.st = dpram_host_pkg::ST_IDLE;
        end
      end
      default: st_next.st = dpram_host_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_reg                <= '0;
      st_reg.st             <= dpram_host_pkg::ST_IDLE;
      st_reg.pins.sel_b     <= 1'b1;
      st_reg.pins.tok_sel_b <= 1'b1;
      st_reg.pins.wstrobe_b <= 1'b1;
      st_reg.pins.oe_b      <= 1'b1;
      st_reg.role_master    <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  assign sw_rdata_o        = st_reg.rd_out;
  assign dev_ce_b_o        = st_reg.pins.sel_b;
  assign dev_tok_sel_b_o   = st_reg.pins.tok_sel_b;
  assign dev_wstrobe_b_o   = st_reg.pins.wstrobe_b;
  assign dev_oe_b_o        = st_reg.pins.oe_b;
  assign dev_addr_o        = st_reg.pins.addr;
  assign dev_data_o        = st_reg.pins.dout;
  assign dev_data_oe_o     = st_reg.pins.dout_en;
  assign dev_role_master_o = st_reg.role_master;

  property p_never_both;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    !(!dev_ce_b_o && !dev_tok_sel_b_o);
  endproperty
  a_never_both: assert property (p_never_both)
    else $error("enable and token select low together");
  property p_strobe_needs_sel;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    !dev_wstrobe_b_o |-> (!dev_ce_b_o || !dev_tok_sel_b_o);
  endproperty
  a_strobe_needs_sel: assert property (p_strobe_needs_sel)
    else $error("strobe low without a select");
  property p_addr_stable;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    !$stable(dev_addr_o) |-> dev_wstrobe_b_o && $past(dev_wstrobe_b_o);
  endproperty
  a_addr_stable: assert property (p_addr_stable)
    else $error("address moved with strobe low");
  property p_read_oe;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    st_reg.st == dpram_host_pkg::ST_READ |-> !dev_oe_b_o && dev_wstrobe_b_o;
  endproperty
  a_read_oe: assert property (p_read_oe)
    else $error("read without output drive");
  property p_tok_ce_high;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    !dev_tok_sel_b_o |-> dev_ce_b_o;
  endproperty
  a_tok_ce_high: assert property (p_tok_ce_high)
    else $error("enable low during token access");
  property p_gap;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    $rose(dev_tok_sel_b_o) |-> dev_tok_sel_b_o [*3];
  endproperty
  a_gap: assert property (p_gap)
    else $error("token select reasserted too soon");
  property p_pulse;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    $fell(dev_wstrobe_b_o) |-> !dev_wstrobe_b_o [*5];
  endproperty
  a_pulse: assert property (p_pulse)
    else $error("write pulse too short");
  property p_no_drive_read;
    @(posedge ref_clk_i) disable iff (!rst_b_i)
    dev_data_oe_o |-> dev_oe_b_o;
  endproperty
  a_no_drive_read: assert property (p_no_drive_read)
    else $error("host drives data while device may drive");
  c_write: cover property (@(posedge ref_clk_i) $rose(dev_wstrobe_b_o) && !dev_ce_b_o);
  c_tok: cover property (@(posedge ref_clk_i) $rose(dev_wstrobe_b_o) && !dev_tok_sel_b_o);
  c_read: cover property (@(posedge ref_clk_i) $rose(dev_oe_b_o) && !dev_ce_b_o);
endmodule : dpram_host
`default_nettype wire

// ===== sim/dpram_dev_model.sv
// Purpose: behavioural model of the ram device, host on the left port
// Assumes: host holds selects, address and data steady through each access
// Notes: right port is reached only through tasks; no contention timing modelled
`timescale 1ns/10ps
`default_nettype none
module dpram_dev_model (
  input  wire logic        ce_b_i,
  input  wire logic        tok_b_i,
  input  wire logic        we_b_i,
  input  wire logic        oe_b_i,
  input  wire logic [11:0] addr_i,
  input  wire logic [8:0]  data_i,
  input  wire logic        busy_in_b_i,
  output logic [8:0]       data_o,
  output logic             mbox_b_o,
  output logic             busy_b_o
);
  logic [8:0] mem [0:4095];
  logic [7:0] own [2];
  logic [7:0] req [2];
  logic [8:0] last     = 9'h000;
  logic [8:0] tok_q    = 9'h1ff;
  logic       mbox_r_b = 1'b1;
  wire rd_arr = !ce_b_i && tok_b_i && !oe_b_i && we_b_i;
  wire rd_tok = ce_b_i && !tok_b_i && !oe_b_i && we_b_i;
  wire wr_arr = !ce_b_i && tok_b_i && !we_b_i;
  wire wr_tok = ce_b_i && !tok_b_i && !we_b_i;
  initial begin
    mbox_b_o = 1'b1;
    own = '{8'h00, 8'h00};
    req = '{8'h00, 8'h00};
  end
  // busy comes from the bench on this side only, so one side at most
  assign busy_b_o = busy_in_b_i;
  // a released bus shows the inverse of the last value, never a held copy
  assign data_o = rd_arr ? mem[addr_i] : (rd_tok ? tok_q : ~last);
  always @(data_o) if (rd_arr || rd_tok) last = data_o;
  // latched after the select settles, so other-port writes cannot disturb it
  always @(posedge rd_tok) #1 tok_q = {9{!own[0][addr_i[2:0]]}};
  always @(negedge wr_arr) if (busy_in_b_i) begin
    mem[addr_i] = data_i;
    if (addr_i == 12'h0fff) mbox_r_b = 1'b0;
  end
  always @(negedge rd_arr) if (addr_i == 12'h0ffe) mbox_b_o = 1'b1;
  always @(negedge wr_tok) tok_wr(0, int'(addr_i[2:0]), data_i[0]);
  // calls are sequential, so exactly one side ever wins a request
  task automatic tok_wr(input int s, input int i, input logic v);
    if (!v) begin
      if (!own[1-s][i]) own[s][i] = 1'b1;
      else req[s][i] = 1'b1;
    end else begin
      own[s][i] = 1'b0;
      req[s][i] = 1'b0;
      if (req[1-s][i]) begin
        own[1-s][i] = 1'b1;
        req[1-s][i] = 1'b0;
      end
    end
  endtask : tok_wr
  task automatic right_wr(input logic [11:0] a, input logic [8:0] d);
    mem[a] = d;
    if (a == 12'h0ffe) mbox_b_o = 1'b0;
  endtask : right_wr
  task automatic right_rd(input logic [11:0] a, output logic [8:0] d);
    d = mem[a];
    if (a == 12'h0fff) mbox_r_b = 1'b1;
  endtask : right_rd
endmodule : dpram_dev_model
`default_nettype wire

// ===== sim/dpram_host_test.sv
// Purpose: self-checking bench for dpram_host against the device model
// Assumes: 250 MHz clock, host on the left port
// Notes: expected data live in a bench array, never read back from the design
`timescale 1ns/10ps
`default_nettype none
module dpram_host_test;
  logic        ref_clk_i  = 1'b0;
  logic        rst_b_i    = 1'b0;
  logic        sw_wr_i    = 1'b0;
  logic        sw_rd_i    = 1'b0;
  logic        busy_in_b  = 1'b1;
  logic [3:0]  sw_addr_i  = 4'h0;
  logic [31:0] sw_wdata_i = 32'h0000_0000;
  logic [31:0] lfsr       = 32'h1973_1dca;
  logic [31:0] sw_rdata_o, r;
  logic        ce_b, tok_b, we_b, oe_b, d_oe, mbox_b, busy_b, role;
  logic [11:0] addr, ra;
  logic [8:0]  dq_o, dev_q, q;
  logic [8:0]  exp_mem [0:4095];
  logic [11:0] aq [$];
  int          miscompares, checks_done, n;
  wire  [8:0]  bus = d_oe ? dq_o : dev_q;
  dpram_host dpram_host_i (
    .ref_clk_i(ref_clk_i), .rst_b_i(rst_b_i), .sw_addr_i(sw_addr_i),
    .sw_wdata_i(sw_wdata_i), .sw_wr_i(sw_wr_i), .sw_rd_i(sw_rd_i), .sw_rdata_o(sw_rdata_o),
    .dev_ce_b_o(ce_b), .dev_tok_sel_b_o(tok_b), .dev_wstrobe_b_o(we_b), .dev_oe_b_o(oe_b),
    .dev_addr_o(addr), .dev_data_i(bus), .dev_data_o(dq_o), .dev_data_oe_o(d_oe),
    .dev_mbox_b_i(mbox_b), .dev_busy_b_i(busy_b), .dev_role_master_o(role));
  dpram_dev_model dpram_dev_model_i (
    .ce_b_i(ce_b), .tok_b_i(tok_b), .we_b_i(we_b), .oe_b_i(oe_b), .addr_i(addr),
    .data_i(bus), .busy_in_b_i(busy_in_b), .data_o(dev_q), .mbox_b_o(mbox_b),
    .busy_b_o(busy_b));
  initial begin
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic sw_write(input logic [3:0] a, input logic [31:0] d);
    sw_addr_i  <= a;
    sw_wdata_i <= d;
    sw_wr_i    <= 1'b1;
    @(posedge ref_clk_i);
    sw_wr_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask : sw_write
  task automatic sw_read(input logic [3:0] a, output logic [31:0] d);
    sw_addr_i <= a;
    sw_rd_i   <= 1'b1;
    @(posedge ref_clk_i);
    sw_rd_i <= 1'b0;
    #1 d = sw_rdata_o;
    @(posedge ref_clk_i);
  endtask : sw_read
  task automatic start(input logic [1:0] c, input logic [11:0] a, input logic [8:0] d);
    sw_write(dpram_host_pkg::REG_ADDR, 32'(a));
    sw_write(dpram_host_pkg::REG_WDATA, 32'(d));
    sw_write(dpram_host_pkg::REG_CMD, 32'(c));
  endtask : start
  // bounded poll: a hung access shows up as a mismatch, not a stall
  task automatic wait_done(output logic [8:0] d);
    n = 0;
    r = 32'h0000_0001;
    while (r[0] === 1'b1 && n < 200) begin
      sw_read(dpram_host_pkg::REG_STATUS, r);
      n++;
    end
    check("access done", 32'h0000_0000, 32'(r[0]));
    sw_read(dpram_host_pkg::REG_RDATA, r);
    d = r[8:0];
  endtask : wait_done
  task automatic access(input logic [1:0] c, input logic [11:0] a, input logic [8:0] d);
    start(c, a, d);
    wait_done(q);
  endtask : access
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial begin
    repeat (20000) @(posedge ref_clk_i);
    miscompares++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge ref_clk_i);
    check("reset pins", 32'h0000_003d, 32'({ce_b, tok_b, we_b, oe_b, d_oe, role}));
    rst_b_i <= 1'b1;
    @(posedge ref_clk_i);
    sw_read(dpram_host_pkg::REG_STATUS, r);
    check("status", 32'h0000_0010, r);
    sw_read(4'hf, r);
    check("unmapped", 32'h0000_0000, r);
    for (int i = 0; i < 12; i++) begin
      lfsr = lfsr_next(lfsr);
      ra = {1'b0, lfsr[10:0]};
      exp_mem[ra] = lfsr[28:20];
      aq.push_back(ra);
      access(dpram_host_pkg::CMD_WR, ra, lfsr[28:20]);
    end
    foreach (aq[i]) begin
      access(dpram_host_pkg::CMD_RD, aq[i], 9'h000);
      check("array read", 32'(exp_mem[aq[i]]), 32'(q));
    end
    dpram_dev_model_i.right_rd(aq[0], q);
    check("cross read", 32'(exp_mem[aq[0]]), 32'(q));
    dpram_dev_model_i.right_wr(12'h0ffe, 9'h1a5);
    repeat (8) @(posedge ref_clk_i);
    sw_read(dpram_host_pkg::REG_STATUS, r);
    check("mailbox set", 32'h0000_0001, 32'(r[2]));
    access(dpram_host_pkg::CMD_RD, 12'h0ffe, 9'h000);
    check("mailbox word", 32'h0000_01a5, 32'(q));
    repeat (8) @(posedge ref_clk_i);
    sw_read(dpram_host_pkg::REG_STATUS, r);
    check("mailbox clear", 32'h0000_0000, 32'(r[2]));
    access(dpram_host_pkg::CMD_WR, 12'h0fff, 9'h05a);
    check("right flag set", 32'h0000_0000, 32'(dpram_dev_model_i.mbox_r_b));
    dpram_dev_model_i.right_rd(12'h0fff, q);
    check("right flag clear", 32'h0000_0001, 32'(dpram_dev_model_i.mbox_r_b));
    check("right word", 32'h0000_005a, 32'(q));
    dpram_dev_model_i.tok_wr(1, 2, 1'b0);
    access(dpram_host_pkg::CMD_TOK_WR, 12'h00a, 9'h000);
    access(dpram_host_pkg::CMD_TOK_RD, 12'h7f2, 9'h000);
    check("token denied", 32'h0000_01ff, 32'(q));
    dpram_dev_model_i.tok_wr(1, 2, 1'b1);
    access(dpram_host_pkg::CMD_TOK_RD, 12'h002, 9'h000);
    check("token granted", 32'h0000_0000, 32'(q));
    access(dpram_host_pkg::CMD_TOK_WR, 12'h002, 9'h1ff);
    access(dpram_host_pkg::CMD_TOK_RD, 12'h002, 9'h000);
    check("token freed", 32'h0000_01ff, 32'(q));
    busy_in_b <= 1'b0;
    sw_write(dpram_host_pkg::REG_STATUS, 32'h0000_0000);
    check("slave role pin", 32'h0000_0000, 32'(role));
    start(dpram_host_pkg::CMD_WR, 12'h123, 9'h0c3);
    sw_write(dpram_host_pkg::REG_ADDR, 32'h0000_0456);
    n = 0;
    repeat (40) begin
      @(posedge ref_clk_i);
      n += int'(we_b === 1'b0);
    end
    check("slave stall", 32'h0000_0000, 32'(n));
    sw_read(dpram_host_pkg::REG_STATUS, r);
    check("stall status", 32'h0000_000b, 32'(r[3:0]));
    busy_in_b <= 1'b1;
    wait_done(q);
    access(dpram_host_pkg::CMD_RD, 12'h123, 9'h000);
    check("slave write", 32'h0000_00c3, 32'(q));
    sw_write(dpram_host_pkg::REG_STATUS, 32'h0000_0010);
    finish_test();
  end
endmodule : dpram_host_test
`default_nettype wire
